// ### src/udr_regs.svh
`ifndef UDR_REGS_SVH
`define UDR_REGS_SVH
// Overview of operation
// - Both serial ports behave identically
// - Bit rate from 40 MHz, max one thirty-second
// - Rate is sixteenth clock over integer divisor
// - Codes 1-15 select rates, default nine
// - Transmit and receive run simultaneously
// - DMA writes each received byte to buffer
// - Input buffer wraps to base after end
// - Buffer base, length, baud code configurable
// - Default frame eight data, one stop, none
// - Frame format changeable through port control
// - Full buffer overwritten silently, no stall
// - Pending query returns head minus tail distance
// - Fetch returns oldest byte, advances tail
// - Reception runs until reset or close
// - Transmit service sends next ring byte
// - Empty ring disables transmit service
// - After last byte busy flag clears
// - No sending until transmit request enables
// - Close stops transmit, receive and service

`define UDR_AW          8
`define UDR_CLK_HZ      200000000
`define UDR_SYS_HZ      40000000
`define UDR_PRE_CYC     (`UDR_CLK_HZ / `UDR_SYS_HZ)
`define UDR_OVS         16
`define UDR_DIV(b)      ((`UDR_SYS_HZ / `UDR_OVS + (b) / 2) / (b))

`define UDR_BAUD_1      110
`define UDR_BAUD_2      150
`define UDR_BAUD_3      300
`define UDR_BAUD_4      600
`define UDR_BAUD_5      1200
`define UDR_BAUD_6      2400
`define UDR_BAUD_7      4800
`define UDR_BAUD_8      9600
`define UDR_BAUD_9      19200
`define UDR_BAUD_10     38400
`define UDR_BAUD_11     57600
`define UDR_BAUD_12     115200
`define UDR_BAUD_13     250000
`define UDR_BAUD_14     500000
`define UDR_BAUD_15     1250000

`define UDR_PORT_BIT    5
`define UDR_OFF_CTRL    5'h00
`define UDR_OFF_RXBUF   5'h04
`define UDR_OFF_RXCNT   5'h08
`define UDR_OFF_RXDATA  5'h0C
`define UDR_OFF_TXDATA  5'h10
`define UDR_OFF_STAT    5'h14

`define UDR_CTRL_EN     0
`define UDR_CTRL_CODE   1
`define UDR_CTRL_DBITS  5
`define UDR_CTRL_STOP2  7
`define UDR_CTRL_PAREN  8
`define UDR_CTRL_PARODD 9
`define UDR_CTRL_TXIE   10
`define UDR_RXBUF_SIZE  16

`define UDR_RST_CODE    4'h9
`define UDR_RST_DBITS   2'h3
`endif

// ### src/udr_pkg.sv
`include "udr_regs.svh"
package udr_pkg;
	localparam int AW = `UDR_AW;

	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} udr_rx_e;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} udr_tx_e;

	typedef struct packed {
		logic          en;
		logic [3:0]    code;
		logic [1:0]    dbits;
		logic          stop2;
		logic          par_en;
		logic          par_odd;
		logic          txie;
		logic          busy;
		logic [AW-1:0] rbase;
		logic [AW:0]   rsize;
		logic [AW-1:0] rhead;
		logic [AW-1:0] rtail;
		logic [AW-1:0] thead;
		logic [AW-1:0] ttail;
		logic [2:0]    pre;
		logic [15:0]   bdiv;
		logic [1:0]    rsync;
		udr_rx_e       rst;
		logic [3:0]    rtick;
		logic [3:0]    rbit;
		logic [7:0]    rsh;
		udr_tx_e       tst;
		logic [3:0]    ttick;
		logic [3:0]    tbit;
		logic [7:0]    tsh;
		logic          tpar;
		logic          txd;
	} udr_port_s;

	typedef struct packed {
		udr_port_s [1:0] port;
		logic            pready;
		logic            pslverr;
		logic [31:0]     prdata;
	} udr_state_s;
endpackage

// ### src/udr_top.sv
`timescale 1ns/1ps
`include "udr_regs.svh"
module udr_top import udr_pkg::*; (
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [1:0]  RXD,
	output logic      [1:0]  TXD
);
	localparam int DEPTH = 1 << AW;
	localparam logic [2:0] PRE_LAST = 3'(`UDR_PRE_CYC - 1);

	udr_state_s    r_reg;
	udr_state_s    s_next;
	logic [7:0]    rx_mem [2][DEPTH];
	logic [7:0]    tx_mem [2][DEPTH];
	logic [1:0]    rx_we;
	logic [AW-1:0] rx_wa [2];
	logic [7:0]    rx_wd [2];
	logic          tx_we;
	logic          tx_wp;
	logic [AW-1:0] tx_wa;
	logic [7:0]    tx_wd;
	logic [1:0]    tick;
	logic [15:0]   div [2];
	logic [AW:0]   esz [2];
	logic [3:0]    nbits [2];
	logic          acc;
	logic          done;
	logic          psel_p;
	logic [4:0]    off;
	logic          mapped;
	logic [AW:0]   cnt;

	function automatic logic [15:0] div_of(input logic [3:0] code);
		case (code)
			4'h1: div_of = 16'(`UDR_DIV(`UDR_BAUD_1));
			4'h2: div_of = 16'(`UDR_DIV(`UDR_BAUD_2));
			4'h3: div_of = 16'(`UDR_DIV(`UDR_BAUD_3));
			4'h4: div_of = 16'(`UDR_DIV(`UDR_BAUD_4));
			4'h5: div_of = 16'(`UDR_DIV(`UDR_BAUD_5));
			4'h6: div_of = 16'(`UDR_DIV(`UDR_BAUD_6));
			4'h7: div_of = 16'(`UDR_DIV(`UDR_BAUD_7));
			4'h8: div_of = 16'(`UDR_DIV(`UDR_BAUD_8));
			4'hA: div_of = 16'(`UDR_DIV(`UDR_BAUD_10));
			4'hB: div_of = 16'(`UDR_DIV(`UDR_BAUD_11));
			4'hC: div_of = 16'(`UDR_DIV(`UDR_BAUD_12));
			4'hD: div_of = 16'(`UDR_DIV(`UDR_BAUD_13));
			4'hE: div_of = 16'(`UDR_DIV(`UDR_BAUD_14));
			4'hF: div_of = 16'(`UDR_DIV(`UDR_BAUD_15));
			default: div_of = 16'(`UDR_DIV(`UDR_BAUD_9));
		endcase
	endfunction

	// Ring step inside base .. base+size-1, also wrapping to base at the array end
	function automatic logic [AW-1:0] ring_inc(input logic [AW-1:0] p, input logic [AW-1:0] b,
			input logic [AW:0] es);
		logic [AW:0] last;
		last = (AW+1)'({1'b0, b} + es - (AW+1)'(1));
		if ({1'b0, p} >= last || &p)
			ring_inc = b;
		else
			ring_inc = p + AW'(1);
	endfunction

	always_comb begin
		s_next = r_reg;
		rx_we = 2'h0;
		tx_we = 1'b0;
		tx_wp = 1'b0;
		tx_wa = '0;
		tx_wd = 8'h00;
		tick = 2'h0;
		cnt = '0;
		for (int p = 0; p < 2; p++) begin
			rx_wa[p] = r_reg.port[p].rhead;
			rx_wd[p] = 8'h00;
			div[p] = div_of(r_reg.port[p].code);
			esz[p] = (r_reg.port[p].rsize == '0) ? (AW+1)'(DEPTH) : r_reg.port[p].rsize;
			nbits[p] = 4'(r_reg.port[p].dbits) + 4'h5;
			// 40 MHz system tick, then divisor gives sixteen ticks per bit
			tick[p] = (r_reg.port[p].pre == PRE_LAST) &&
				(r_reg.port[p].bdiv >= div[p] - 16'h0001);
			if (r_reg.port[p].pre == PRE_LAST) begin
				s_next.port[p].pre = 3'h0;
				s_next.port[p].bdiv = tick[p] ? 16'h0000 : r_reg.port[p].bdiv + 16'h0001;
			end else begin
				s_next.port[p].pre = r_reg.port[p].pre + 3'h1;
			end
			s_next.port[p].rsync = {r_reg.port[p].rsync[0], RXD[p]};

			// Receiver, runs independently of the transmitter
			if (r_reg.port[p].rst == RX_IDLE) begin
				if (!r_reg.port[p].rsync[1]) begin
					s_next.port[p].rst = RX_START;
					s_next.port[p].rtick = 4'h0;
				end
			end else if (tick[p]) begin
				s_next.port[p].rtick = r_reg.port[p].rtick + 4'h1;
				case (r_reg.port[p].rst)
					RX_START: begin
						if (r_reg.port[p].rtick == 4'h7) begin
							s_next.port[p].rst = r_reg.port[p].rsync[1] ? RX_IDLE : RX_DATA;
							s_next.port[p].rtick = 4'h0;
							s_next.port[p].rbit = 4'h0;
						end
					end
					RX_DATA: begin
						if (r_reg.port[p].rtick == 4'hF) begin
							s_next.port[p].rsh = {r_reg.port[p].rsync[1],
								r_reg.port[p].rsh[7:1]};
							s_next.port[p].rbit = r_reg.port[p].rbit + 4'h1;
							if (r_reg.port[p].rbit == nbits[p] - 4'h1)
								s_next.port[p].rst = r_reg.port[p].par_en ? RX_PAR : RX_STOP;
						end
					end
					RX_PAR: begin
						if (r_reg.port[p].rtick == 4'hF)
							s_next.port[p].rst = RX_STOP;
					end
					RX_STOP: begin
						if (r_reg.port[p].rtick == 4'hF) begin
							s_next.port[p].rst = RX_IDLE;
							if (r_reg.port[p].rsync[1]) begin
								// DMA store, overwriting unread data when full
								rx_we[p] = 1'b1;
								rx_wd[p] = r_reg.port[p].rsh >> (4'h8 - nbits[p]);
								s_next.port[p].rhead = ring_inc(r_reg.port[p].rhead,
									r_reg.port[p].rbase, esz[p]);
							end
						end
					end
					default: s_next.port[p].rst = RX_IDLE;
				endcase
			end

			// Transmit service, active only after a transmit request
			if (r_reg.port[p].tst == TX_IDLE) begin
				s_next.port[p].txd = 1'b1;
				if (r_reg.port[p].txie) begin
					if (r_reg.port[p].thead == r_reg.port[p].ttail) begin
						s_next.port[p].txie = 1'b0;
						s_next.port[p].busy = 1'b0;
					end else begin
						s_next.port[p].tsh = tx_mem[p][r_reg.port[p].ttail] &
							(8'hFF >> (4'h8 - nbits[p]));
						s_next.port[p].ttail = r_reg.port[p].ttail + AW'(1);
						s_next.port[p].busy = 1'b1;
						s_next.port[p].tst = TX_START;
						s_next.port[p].ttick = 4'h0;
						s_next.port[p].txd = 1'b0;
					end
				end
			end else if (tick[p]) begin
				s_next.port[p].ttick = r_reg.port[p].ttick + 4'h1;
				if (r_reg.port[p].ttick == 4'hF) begin
					case (r_reg.port[p].tst)
						TX_START: begin
							s_next.port[p].tst = TX_DATA;
							s_next.port[p].tbit = 4'h0;
							s_next.port[p].txd = r_reg.port[p].tsh[0];
							s_next.port[p].tpar = (^r_reg.port[p].tsh) ^ r_reg.port[p].par_odd;
							s_next.port[p].tsh = r_reg.port[p].tsh >> 1;
						end
						TX_DATA: begin
							s_next.port[p].tbit = r_reg.port[p].tbit + 4'h1;
							s_next.port[p].txd = r_reg.port[p].tsh[0];
							s_next.port[p].tsh = r_reg.port[p].tsh >> 1;
							if (r_reg.port[p].tbit == nbits[p] - 4'h1) begin
								s_next.port[p].tst = r_reg.port[p].par_en ? TX_PAR : TX_STOP;
								s_next.port[p].txd = r_reg.port[p].par_en ?
									r_reg.port[p].tpar : 1'b1;
								s_next.port[p].tbit = 4'h0;
							end
						end
						TX_PAR: begin
							s_next.port[p].tst = TX_STOP;
							s_next.port[p].txd = 1'b1;
						end
						TX_STOP: begin
							s_next.port[p].tbit = r_reg.port[p].tbit + 4'h1;
							if (!r_reg.port[p].stop2 || r_reg.port[p].tbit == 4'h1)
								s_next.port[p].tst = TX_IDLE;
						end
						default: s_next.port[p].tst = TX_IDLE;
					endcase
				end
			end

			if (!r_reg.port[p].en) begin
				s_next.port[p].rst = RX_IDLE;
				s_next.port[p].tst = TX_IDLE;
				s_next.port[p].txie = 1'b0;
				s_next.port[p].busy = 1'b0;
				s_next.port[p].txd = 1'b1;
				rx_we[p] = 1'b0;
				s_next.port[p].rhead = r_reg.port[p].rhead;
			end
		end

		// APB slave: one wait state, effects at the completing edge
		acc = PSEL && PENABLE;
		done = acc && r_reg.pready;
		psel_p = PADDR[`UDR_PORT_BIT];
		off = PADDR[4:0];
		mapped = (PADDR[7:6] == 2'h0) && (off <= `UDR_OFF_STAT) && (off[1:0] == 2'h0);
		s_next.pready = acc && !r_reg.pready;
		s_next.pslverr = acc && !r_reg.pready && !mapped;
		s_next.prdata = 32'h0000_0000;
		if (r_reg.port[psel_p].rhead >= r_reg.port[psel_p].rtail)
			cnt = {1'b0, r_reg.port[psel_p].rhead - r_reg.port[psel_p].rtail};
		else
			cnt = (AW+1)'(esz[psel_p] - {1'b0, r_reg.port[psel_p].rtail} +
				{1'b0, r_reg.port[psel_p].rhead});
		if (acc && !r_reg.pready && !PWRITE && mapped) begin
			case (off)
				`UDR_OFF_CTRL: s_next.prdata = 32'({r_reg.port[psel_p].txie,
					r_reg.port[psel_p].par_odd, r_reg.port[psel_p].par_en,
					r_reg.port[psel_p].stop2, r_reg.port[psel_p].dbits,
					r_reg.port[psel_p].code, r_reg.port[psel_p].en});
				`UDR_OFF_RXBUF: s_next.prdata = (32'(r_reg.port[psel_p].rsize) <<
					`UDR_RXBUF_SIZE) | 32'(r_reg.port[psel_p].rbase);
				`UDR_OFF_RXCNT: s_next.prdata = 32'(cnt);
				`UDR_OFF_RXDATA: s_next.prdata =
					32'(rx_mem[psel_p][r_reg.port[psel_p].rtail]);
				`UDR_OFF_STAT: s_next.prdata = 32'({r_reg.port[psel_p].ttail,
					r_reg.port[psel_p].thead, 4'h0, r_reg.port[psel_p].rst == RX_IDLE,
					r_reg.port[psel_p].en, r_reg.port[psel_p].txie, r_reg.port[psel_p].busy});
				default: s_next.prdata = 32'h0000_0000;
			endcase
		end
		if (done && mapped) begin
			if (PWRITE) begin
				case (off)
					`UDR_OFF_CTRL: begin
						// Request bit set here wins over a same-cycle clear by the service
						s_next.port[psel_p].en = PWDATA[`UDR_CTRL_EN];
						s_next.port[psel_p].code = PWDATA[`UDR_CTRL_CODE +: 4];
						s_next.port[psel_p].dbits = PWDATA[`UDR_CTRL_DBITS +: 2];
						s_next.port[psel_p].stop2 = PWDATA[`UDR_CTRL_STOP2];
						s_next.port[psel_p].par_en = PWDATA[`UDR_CTRL_PAREN];
						s_next.port[psel_p].par_odd = PWDATA[`UDR_CTRL_PARODD];
						if (PWDATA[`UDR_CTRL_TXIE] && PWDATA[`UDR_CTRL_EN])
							s_next.port[psel_p].txie = 1'b1;
					end
					`UDR_OFF_RXBUF: begin
						s_next.port[psel_p].rbase = PWDATA[AW-1:0];
						s_next.port[psel_p].rsize = PWDATA[`UDR_RXBUF_SIZE +: AW+1];
						s_next.port[psel_p].rhead = PWDATA[AW-1:0];
						s_next.port[psel_p].rtail = PWDATA[AW-1:0];
						rx_we[psel_p] = 1'b0;
					end
					`UDR_OFF_TXDATA: begin
						tx_we = 1'b1;
						tx_wp = psel_p;
						tx_wa = r_reg.port[psel_p].thead;
						tx_wd = PWDATA[7:0];
						s_next.port[psel_p].thead = r_reg.port[psel_p].thead + AW'(1);
					end
					default: ;
				endcase
			end else if (off == `UDR_OFF_RXDATA) begin
				s_next.port[psel_p].rtail = ring_inc(r_reg.port[psel_p].rtail,
					r_reg.port[psel_p].rbase, esz[psel_p]);
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			r_reg <= '0;
			for (int p = 0; p < 2; p++) begin
				r_reg.port[p].code <= `UDR_RST_CODE;
				r_reg.port[p].dbits <= `UDR_RST_DBITS;
				r_reg.port[p].rsync <= 2'h3;
				r_reg.port[p].txd <= 1'b1;
			end
		end else begin
			r_reg <= s_next;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		for (int p = 0; p < 2; p++)
			if (rx_we[p])
				rx_mem[p][rx_wa[p]] <= rx_wd[p];
		if (tx_we)
			tx_mem[tx_wp][tx_wa] <= tx_wd;
	end

	assign PRDATA = r_reg.prdata;
	assign PREADY = r_reg.pready;
	assign PSLVERR = r_reg.pslverr;
	assign TXD = {r_reg.port[1].txd, r_reg.port[0].txd};

	// Helper: cycles between baud ticks of port A
	logic [19:0] gap_reg;
	logic        gap_vld_reg;
	always_ff @(posedge CORE_CLK) begin
		if (RST || done) begin
			gap_reg <= 20'h00000;
			gap_vld_reg <= 1'b0;
		end else if (tick[0]) begin
			gap_reg <= 20'h00000;
			gap_vld_reg <= 1'b1;
		end else begin
			gap_reg <= gap_reg + 20'h00001;
		end
	end

	property p_tick_gap;
		@(posedge CORE_CLK) disable iff (RST)
		(tick[0] && gap_vld_reg) |-> (gap_reg == 20'(div[0]) * 20'(`UDR_PRE_CYC) - 20'h00001);
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("baud tick spacing wrong");

	property p_reset_frame;
		@(posedge CORE_CLK) $fell(RST) |-> (r_reg.port[0].dbits == 2'h3 &&
			!r_reg.port[0].par_en && !r_reg.port[0].stop2 && r_reg.port[0].code == 4'h9);
	endproperty
	a_reset_frame: assert property (p_reset_frame) else $error("reset frame wrong");

	property p_empty_stop;
		@(posedge CORE_CLK) disable iff (RST)
		(r_reg.port[0].txie && r_reg.port[0].tst == TX_IDLE &&
			r_reg.port[0].thead == r_reg.port[0].ttail && !done)
		|=> (!r_reg.port[0].txie && !r_reg.port[0].busy);
	endproperty
	a_empty_stop: assert property (p_empty_stop) else $error("service not stopped");

	property p_no_request;
		@(posedge CORE_CLK) disable iff (RST)
		(!r_reg.port[0].txie && r_reg.port[0].tst == TX_IDLE)
		|=> (r_reg.port[0].tst == TX_IDLE && TXD[0]);
	endproperty
	a_no_request: assert property (p_no_request) else $error("sent without request");

	property p_close;
		@(posedge CORE_CLK) disable iff (RST)
		!r_reg.port[1].en |=> (r_reg.port[1].tst == TX_IDLE &&
			r_reg.port[1].rst == RX_IDLE && $stable(r_reg.port[1].rhead));
	endproperty
	a_close: assert property (p_close) else $error("closed port active");

	property p_wrap;
		@(posedge CORE_CLK) disable iff (RST)
		(rx_we[0] && !done && {1'b0, r_reg.port[0].rhead} ==
			(AW+1)'({1'b0, r_reg.port[0].rbase} + esz[0] - 1))
		|=> (r_reg.port[0].rhead == r_reg.port[0].rbase);
	endproperty
	a_wrap: assert property (p_wrap) else $error("ring did not wrap");

	property p_overwrite;
		@(posedge CORE_CLK) disable iff (RST)
		(r_reg.port[0].rst == RX_STOP && tick[0] && r_reg.port[0].rtick == 4'hF &&
			r_reg.port[0].rsync[1] && r_reg.port[0].en) |-> rx_we[0];
	endproperty
	a_overwrite: assert property (p_overwrite) else $error("byte not stored");

	property p_pop;
		@(posedge CORE_CLK) disable iff (RST)
		(done && !PWRITE && mapped && off == `UDR_OFF_RXDATA && !psel_p)
		|=> (r_reg.port[0].rtail != $past(r_reg.port[0].rtail) || esz[0] == 1);
	endproperty
	a_pop: assert property (p_pop) else $error("tail not advanced");

	property p_apb_wait;
		@(posedge CORE_CLK) disable iff (RST)
		(PSEL && PENABLE && !PREADY) |=> PREADY ##1 !PREADY;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing wrong");

	property p_busy_clear;
		@(posedge CORE_CLK) disable iff (RST)
		$fell(r_reg.port[0].busy) |-> (r_reg.port[0].tst == TX_IDLE && TXD[0]);
	endproperty
	a_busy_clear: assert property (p_busy_clear) else $error("busy cleared early");
endmodule

// ### testbench/udr_peer.sv
`timescale 1ns/1ps
module udr_peer #(
	parameter int BIT_CYC = 160
) (
	input  wire logic       clk,
	input  wire logic       txd,
	input  wire logic [3:0] len,
	output logic            rxd
);
	logic [8:0] got [$];
	logic [8:0] sh;

	initial rxd = 1'b1;

	// Same rate and frame as the port, line idles high between frames
	task automatic send(input logic [8:0] d, input int n);
		@(posedge clk);
		rxd <= 1'b0;
		repeat (BIT_CYC) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			rxd <= d[i];
			repeat (BIT_CYC) @(posedge clk);
		end
		rxd <= 1'b1;
		repeat (BIT_CYC) @(posedge clk);
	endtask

	// Samples mid-bit, keeps only frames with a valid stop bit
	always @(negedge txd) begin
		repeat (BIT_CYC / 2) @(posedge clk);
		if (txd === 1'b0) begin
			sh = '0;
			for (int i = 0; i < len; i++) begin
				repeat (BIT_CYC) @(posedge clk);
				sh[i] = txd;
			end
			repeat (BIT_CYC) @(posedge clk);
			if (txd === 1'b1) begin
				got.push_back(sh);
			end
		end
	end
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam int LIMIT = 60000;

	logic        clk     = 1'b0;
	logic        rst     = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	wire  [1:0]  rxd;
	wire  [1:0]  txd;
	logic [3:0]  len_a   = 4'h8;
	logic [31:0] rd;
	logic        err;
	logic [8:0]  v;
	logic [7:0]  bad [3] = '{8'h18, 8'h40, 8'h03};
	int          mismatches = 0;
	int          checks     = 0;
	int          cycles     = 0;

	always #2.5 clk = ~clk;

	udr_top uut (
		.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .RXD(rxd), .TXD(txd)
	);

	udr_peer peer_a (.clk(clk), .txd(txd[0]), .len(len_a), .rxd(rxd[0]));
	udr_peer peer_b (.clk(clk), .txd(txd[1]), .len(4'h8), .rxd(rxd[1]));

	task automatic end_of_test();
		if (mismatches == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Holds the request until PREADY is sampled high, then releases it
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(rd, exp);
	endtask

	task automatic get_tx(input int p, input logic [8:0] exp);
		int n;
		n = 0;
		while ((p ? peer_b.got.size() : peer_a.got.size()) == 0 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		v = 9'h1FF;
		if (n < 4000) begin
			v = p ? peer_b.got.pop_front() : peer_a.got.pop_front();
		end
		check({23'h0, v}, {23'h0, exp});
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rdchk(8'h00, 32'h0000_0072);
		rdchk(8'h20, 32'h0000_0072);
		rdchk(8'h08, 32'h0000_0000);
		foreach (bad[i]) begin
			rdchk(bad[i], 32'h0000_0000);
			check({31'h0, err}, 32'h0000_0001);
		end
		// Queued bytes wait for the transmit request
		wr(8'h00, 32'h0000_007F);
		wr(8'h04, 32'h0004_0010);
		wr(8'h10, 32'h0000_0055);
		wr(8'h10, 32'h0000_00A3);
		repeat (400) @(posedge clk);
		check(32'(peer_a.got.size()), 32'h0000_0000);
		check({31'h0, txd[0]}, 32'h0000_0001);
		wr(8'h00, 32'h0000_047F); // Ring untouched while sending
		get_tx(0, 9'h055);
		get_tx(0, 9'h0A3);
		repeat (200) @(posedge clk);
		apb(1'b0, 8'h14, 32'h0000_0000);
		check(rd & 32'h0000_0007, 32'h0000_0004);
		rdchk(8'h00, 32'h0000_007F);
		// Receive ring of four bytes, then overrun it
		peer_a.send(9'h011, 8);
		peer_a.send(9'h022, 8);
		peer_a.send(9'h033, 8);
		repeat (40) @(posedge clk);
		rdchk(8'h08, 32'h0000_0003);
		rdchk(8'h0C, 32'h0000_0011);
		rdchk(8'h0C, 32'h0000_0022);
		rdchk(8'h0C, 32'h0000_0033);
		rdchk(8'h08, 32'h0000_0000);
		for (int i = 0; i < 5; i++) begin
			peer_a.send(9'h040 + 9'(i), 8);
		end
		repeat (40) @(posedge clk);
		rdchk(8'h08, 32'h0000_0001);
		rdchk(8'h0C, 32'h0000_0044);
		// Second port sends and receives at once
		wr(8'h20, 32'h0000_007F);
		wr(8'h24, 32'h0008_0000);
		wr(8'h30, 32'h0000_003C);
		wr(8'h20, 32'h0000_047F); // Ring untouched while sending
		fork
			peer_b.send(9'h0C3, 8);
			get_tx(1, 9'h03C);
		join
		repeat (40) @(posedge clk);
		rdchk(8'h28, 32'h0000_0001);
		rdchk(8'h2C, 32'h0000_00C3);
		// Seven data bits with even parity
		wr(8'h00, 32'h0000_015F);
		wr(8'h10, 32'h0000_0057);
		wr(8'h00, 32'h0000_055F);
		get_tx(0, 9'h0D7);
		peer_a.send(9'h0D7, 8);
		repeat (40) @(posedge clk);
		rdchk(8'h0C, 32'h0000_0057);
		// Eight data bits, odd parity, two stop bits
		len_a <= 4'h9;
		wr(8'h00, 32'h0000_03FF);
		wr(8'h10, 32'h0000_0096);
		wr(8'h00, 32'h0000_07FF);
		get_tx(0, 9'h196);
		// Second stop bit keeps the transmitter busy
		repeat (160) @(posedge clk);
		apb(1'b0, 8'h14, 32'h0000_0000);
		check(rd & 32'h0000_0001, 32'h0000_0001);
		peer_a.send(9'h1A5, 9);
		repeat (40) @(posedge clk);
		rdchk(8'h0C, 32'h0000_00A5);
		// Closed port neither sends nor receives
		wr(8'h00, 32'h0000_0000);
		apb(1'b0, 8'h14, 32'h0000_0000);
		check(rd & 32'h0000_0007, 32'h0000_0000);
		wr(8'h10, 32'h0000_0066);
		wr(8'h00, 32'h0000_0400);
		peer_a.send(9'h099, 8);
		repeat (400) @(posedge clk);
		check(32'(peer_a.got.size()), 32'h0000_0000);
		rdchk(8'h08, 32'h0000_0000);
		end_of_test();
	end
endmodule
